//--- sync_serial_status_and_holding.sv
// Sync serial data, compare and event flag registers with serial link
// ------------------------------------------------------------------
// Functional notes
// RQ1 - Transmit word right aligned, masked to length
// RQ2 - Received sync data in bits 15..0
// RQ3 - Transmit sync data field, read and write
// RQ4 - Two 16-bit receive compare values
// RQ5 - Bit 0 shows transmit holding empty
// RQ6 - Bit 1 set when everything sent
// RQ7 - Bit 2 transmit count end, write clears
// RQ8 - Bit 3 both transmit counts zero
// RQ9 - Bit 4 receive word waiting
// RQ10 - Bit 5 overrun, cleared by status read
// RQ11 - Bit 6 receive count end, write clears
// RQ12 - Bit 7 both receive counts zero
// RQ13 - Bits 8,9 compare events until status read
// RQ14 - Bits 10,11 sync events until status read
// RQ15 - Bits 16,17 show transmit, receive enabled
// RQ16 - Enable register sets mask bits written one
// RQ17 - Disable register clears mask bits written one
// RQ18 - Mask register readable, one means enabled
// RQ19 - Serial word is length plus one bits
// RQ20 - Sync data sent during frame sync
// RQ21 - Interrupt high on any enabled flag
// ------------------------------------------------------------------
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
module sync_serial_status_and_holding (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic serial_clk_i,
	input wire logic rx_data_i,
	input wire logic rx_sync_i,
	output logic tx_data_o,
	output logic tx_sync_o,
	output logic irq_o
);
	import sync_serial_pkg::*;
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic req, wr, rd, ack;
	logic [31:0] wmask, next_rdata, flags, ctrl;
	logic [31:0] tx_hold, rx_hold;
	logic [SYNC_W-1:0] tx_sync_word, rx_sync_word, match_a, match_b;
	logic [IRQ_W-1:0] imask;
	logic tx_free, tx_load, tx_busy, tx_all_done, tx_sync_evt;
	logic rx_ready, rx_load, rx_sync_evt, rx_sync_done;
	logic [N_EVT-1:0] ev_flag, ev_set;
	logic [CNT_W-1:0] dma_cnt [2];
	logic [CNT_W-1:0] dma_next [2];
	logic [1:0] dma_end, dma_zero, dma_dec;
	logic sclk_s1, sclk_s2, sclk_d, rxd_s1, rxd_s2, rxs_s1, rxs_s2;
	logic sclk_rise, sclk_fall, rsync_prev;
	rx_state_t rx_state;
	logic [BIT_W-1:0] rx_bit;
	logic [31:0] rx_shift;
	logic [SYNC_W-1:0] rx_sync_shift;
	logic [LEN_W-1:0] len;
	logic [SLEN_W-1:0] sync_len;
	logic tx_on, rx_on, irq_any;

	function automatic logic [31:0] len_mask(input logic [LEN_W-1:0] l);
		logic [32:0] m;
		m = (33'h1 << ({28'h0, l} + 33'h1)) - 33'h1;
		return m[31:0];
	endfunction : len_mask

	assign tx_on = ctrl[CTRL_TX_ON];
	assign rx_on = ctrl[CTRL_RX_ON];
	assign len = ctrl[CTRL_LEN_LSB +: LEN_W];
	assign sync_len = ctrl[CTRL_SLEN_LSB +: SLEN_W];
	assign irq_any = |(flags[IRQ_W-1:0] & imask);
	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	assign req = cyc_i & stb_i & ~ack;
	assign wr = req & we_i;
	assign rd = req & ~we_i;
	assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}},
		{8{sel_i[0]}}};
	assign ack_o = ack;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
		end else begin
			ack <= req;
		end
	end

	always_comb begin
		flags = '0;
		flags[FLAG_TX_FREE] = tx_free; // RQ5
		flags[FLAG_TX_DONE] = tx_all_done;
		flags[FLAG_TX_DMA_END] = dma_end[CH_TX];
		flags[FLAG_TX_DMA_EMPTY] = dma_zero[CH_TX]; // RQ8
		flags[FLAG_RX_READY] = rx_ready;
		flags[FLAG_RX_OVERRUN] = ev_flag[0];
		flags[FLAG_RX_DMA_END] = dma_end[CH_RX];
		flags[FLAG_RX_DMA_FULL] = dma_zero[CH_RX]; // RQ12
		flags[FLAG_MATCH_A] = ev_flag[1];
		flags[FLAG_MATCH_B] = ev_flag[2];
		flags[FLAG_TX_SYNC] = ev_flag[3];
		flags[FLAG_RX_SYNC] = ev_flag[4];
		flags[FLAG_TX_ON] = tx_on; // RQ15
		flags[FLAG_RX_ON] = rx_on; // RQ15
	end

	always_comb begin
		next_rdata = '0;
		case (adr_i)
			ADDR_RX_HOLDING: next_rdata = rx_hold;
			ADDR_RX_SYNC: next_rdata = {16'h0000, rx_sync_word}; // RQ2
			ADDR_TX_SYNC: next_rdata = {16'h0000, tx_sync_word}; // RQ3
			ADDR_MATCH_A: next_rdata = {16'h0000, match_a}; // RQ4
			ADDR_MATCH_B: next_rdata = {16'h0000, match_b}; // RQ4
			ADDR_EVENT_FLAGS: next_rdata = flags;
			ADDR_IRQ_MASK: next_rdata = {20'h00000, imask}; // RQ18
			ADDR_LINK_CTRL: next_rdata = ctrl;
			ADDR_TX_DMA_COUNT: next_rdata = {16'h0000, dma_cnt[CH_TX]};
			ADDR_TX_DMA_NEXT: next_rdata = {16'h0000, dma_next[CH_TX]};
			ADDR_RX_DMA_COUNT: next_rdata = {16'h0000, dma_cnt[CH_RX]};
			ADDR_RX_DMA_NEXT: next_rdata = {16'h0000, dma_next[CH_RX]};
			default: next_rdata = '0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= '0;
		end else if (rd) begin
			dat_o <= next_rdata;
		end
	end
	// ----------------------------------------------------------------
	// Writable registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= '0;
			tx_sync_word <= '0;
			match_a <= '0;
			match_b <= '0;
		end else if (wr) begin
			case (adr_i)
				ADDR_LINK_CTRL: ctrl <= (ctrl & ~wmask) |
					(dat_i & wmask & CTRL_RW_MASK);
				ADDR_TX_SYNC: tx_sync_word <= (tx_sync_word &
					~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]); // RQ3
				ADDR_MATCH_A: match_a <= (match_a & ~wmask[15:0]) |
					(dat_i[15:0] & wmask[15:0]); // RQ4
				ADDR_MATCH_B: match_b <= (match_b & ~wmask[15:0]) |
					(dat_i[15:0] & wmask[15:0]); // RQ4
				default: ctrl <= ctrl;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			imask <= '0;
		end else if (wr && adr_i == ADDR_IRQ_SET) begin
			imask <= imask | (dat_i[IRQ_W-1:0] & wmask[IRQ_W-1:0]); // RQ16
		end else if (wr && adr_i == ADDR_IRQ_CLEAR) begin
			imask <= imask & ~(dat_i[IRQ_W-1:0] & wmask[IRQ_W-1:0]); // RQ17
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= irq_any; // RQ21
		end
	end
	// ----------------------------------------------------------------
	// Transmit holding and hand-off to the shifter
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_hold <= '0;
			tx_free <= 1'b1;
			tx_load <= 1'b0;
		end else begin
			tx_load <= tx_on & ~tx_free & ~tx_busy & ~tx_load;
			if (wr && adr_i == ADDR_TX_HOLDING) begin
				tx_hold <= dat_i & wmask & len_mask(len); // RQ1
				tx_free <= 1'b0; // RQ5
			end else if (tx_load) begin
				tx_free <= 1'b1; // RQ5
			end
		end
	end

	assign tx_all_done = tx_free & ~tx_busy & ~tx_load; // RQ6

	sync_serial_tx_shifter u_tx (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_i(sclk_fall),
		.load_i(tx_load),
		.word_i(tx_hold),
		.len_i(len),
		.sync_word_i(tx_sync_word),
		.sync_len_i(sync_len),
		.sync_en_i(ctrl[CTRL_SYNC_SEND]),
		.busy_o(tx_busy),
		.td_o(tx_data_o),
		.tf_o(tx_sync_o),
		.sync_start_o(tx_sync_evt)
	);
	// ----------------------------------------------------------------
	// DMA counters, transmit and receive
	// ----------------------------------------------------------------
	assign dma_dec = {rx_load, tx_load};
	for (genvar ch = 0; ch < 2; ch++) begin : g_dma
		localparam logic [31:0] A_CNT = ch ? ADDR_RX_DMA_COUNT :
			ADDR_TX_DMA_COUNT;
		localparam logic [31:0] A_NXT = ch ? ADDR_RX_DMA_NEXT :
			ADDR_TX_DMA_NEXT;
		logic w_cnt, w_nxt, hit_zero;
		assign w_cnt = wr && adr_i == A_CNT;
		assign w_nxt = wr && adr_i == A_NXT;
		assign hit_zero = dma_dec[ch] && dma_cnt[ch] == 16'h0001;
		assign dma_zero[ch] = dma_cnt[ch] == '0 && dma_next[ch] == '0;
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				dma_cnt[ch] <= '0;
				dma_next[ch] <= '0;
				dma_end[ch] <= 1'b0;
			end else begin
				if (w_cnt) begin
					dma_cnt[ch] <= dat_i[CNT_W-1:0];
				end else if (hit_zero && dma_next[ch] != '0) begin
					dma_cnt[ch] <= dma_next[ch];
				end else if (dma_dec[ch] && dma_cnt[ch] != '0) begin
					dma_cnt[ch] <= dma_cnt[ch] - 1'b1;
				end
				if (w_nxt) begin
					dma_next[ch] <= dat_i[CNT_W-1:0];
				end else if (hit_zero && !w_cnt) begin
					dma_next[ch] <= '0;
				end
				// Reaching zero beats a same-cycle count write
				if (hit_zero) begin
					dma_end[ch] <= 1'b1; // RQ7 RQ11
				end else if (w_cnt || w_nxt) begin
					dma_end[ch] <= 1'b0; // RQ7 RQ11
				end
			end
		end
		property p_end_clear;
			@(posedge clk_i) disable iff (rst_i)
			(w_cnt && !hit_zero) |=> !dma_end[ch];
		endproperty
		a_end_clear: assert property (p_end_clear) else $error("end"); // RQ7
	end
	// ----------------------------------------------------------------
	// Link input synchronisers and edge detection
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{sclk_s1, sclk_s2, sclk_d} <= 3'h0;
			{rxd_s1, rxd_s2, rxs_s1, rxs_s2} <= 4'h0;
		end else begin
			sclk_s1 <= serial_clk_i;
			sclk_s2 <= sclk_s1;
			sclk_d <= sclk_s2;
			rxd_s1 <= rx_data_i;
			rxd_s2 <= rxd_s1;
			rxs_s1 <= rx_sync_i;
			rxs_s2 <= rxs_s1;
		end
	end
	assign sclk_rise = sclk_s2 & ~sclk_d;
	assign sclk_fall = ~sclk_s2 & sclk_d;
	// ----------------------------------------------------------------
	// Receiver: sync phase then data word, sampled on rising edges
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_state <= RX_IDLE;
			rx_bit <= '0;
			rx_shift <= '0;
			rx_sync_shift <= '0;
			rsync_prev <= 1'b0;
			rx_sync_evt <= 1'b0;
			rx_sync_done <= 1'b0;
			rx_load <= 1'b0;
		end else begin
			rx_sync_evt <= 1'b0;
			rx_sync_done <= 1'b0;
			rx_load <= 1'b0;
			if (!rx_on) begin
				rx_state <= RX_IDLE;
			end else if (sclk_rise) begin
				rsync_prev <= rxs_s2;
				case (rx_state)
					RX_IDLE: begin
						if (rxs_s2 && !rsync_prev) begin
							rx_sync_evt <= 1'b1;
							rx_sync_shift <= '0;
							rx_bit <= '0;
							rx_state <= RX_SYNC;
						end
					end
					RX_SYNC: begin
						rx_sync_shift[rx_bit[SLEN_W-1:0]] <= rxd_s2;
						if (rx_bit == {1'b0, sync_len}) begin
							rx_sync_done <= 1'b1;
							rx_shift <= '0;
							rx_bit <= '0;
							rx_state <= RX_DATA;
						end else begin
							rx_bit <= rx_bit + 1'b1;
						end
					end
					RX_DATA: begin
						rx_shift[rx_bit] <= rxd_s2;
						if (rx_bit == len) begin
							rx_load <= 1'b1;
							rx_state <= RX_IDLE;
						end else begin
							rx_bit <= rx_bit + 1'b1;
						end
					end
					default: rx_state <= RX_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_hold <= '0;
			rx_sync_word <= '0;
			rx_ready <= 1'b0;
		end else begin
			if (rx_sync_done) begin
				rx_sync_word <= rx_sync_shift; // RQ2
			end
			if (rx_load) begin
				rx_hold <= rx_shift;
				rx_ready <= 1'b1; // RQ9
			end else if (rd && adr_i == ADDR_RX_HOLDING) begin
				rx_ready <= 1'b0; // RQ9
			end
		end
	end
	// ----------------------------------------------------------------
	// Sticky events cleared by a status read; a new event wins
	// ----------------------------------------------------------------
	assign ev_set[0] = rx_load & rx_ready; // RQ10
	assign ev_set[1] = rx_load & (rx_shift[SYNC_W-1:0] == match_a); // RQ13
	assign ev_set[2] = rx_load & (rx_shift[SYNC_W-1:0] == match_b); // RQ13
	assign ev_set[3] = tx_sync_evt; // RQ14
	assign ev_set[4] = rx_sync_evt; // RQ14

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ev_flag <= '0;
		end else if (rd && adr_i == ADDR_EVENT_FLAGS) begin
			ev_flag <= ev_set; // RQ10 RQ13 RQ14
		end else begin
			ev_flag <= ev_flag | ev_set;
		end
	end
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_write(logic [31:0] a);
		wr && adr_i == a && sel_i[0];
	endsequence
	sequence s_status_read;
		rd && adr_i == ADDR_EVENT_FLAGS;
	endsequence
	property p_hold_busy;
		@(posedge clk_i) disable iff (rst_i)
		s_write(ADDR_TX_HOLDING) |=> !tx_free && !tx_all_done;
	endproperty
	a_hold_busy: assert property (p_hold_busy) else $error("free"); // RQ5
	property p_load_done;
		@(posedge clk_i) disable iff (rst_i)
		tx_load |-> !tx_all_done ##1 tx_busy;
	endproperty
	a_load_done: assert property (p_load_done) else $error("done"); // RQ6
	property p_overrun;
		@(posedge clk_i) disable iff (rst_i)
		rx_load && rx_ready |=> ev_flag[0] && rx_ready;
	endproperty
	a_overrun: assert property (p_overrun) else $error("ovr"); // RQ10
	property p_rx_ready;
		@(posedge clk_i) disable iff (rst_i)
		rx_load |=> rx_ready && rx_hold == $past(rx_shift);
	endproperty
	a_rx_ready: assert property (p_rx_ready) else $error("rdy"); // RQ9
	property p_read_clears;
		@(posedge clk_i) disable iff (rst_i)
		s_status_read and !ev_set[1] && !ev_set[3] |=>
			!ev_flag[1] && !ev_flag[3];
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("clr"); // RQ13
	property p_tx_sync;
		@(posedge clk_i) disable iff (rst_i)
		tx_sync_evt |=> ev_flag[3];
	endproperty
	a_tx_sync: assert property (p_tx_sync) else $error("txsync"); // RQ14
	property p_irq_set;
		@(posedge clk_i) disable iff (rst_i)
		s_write(ADDR_IRQ_SET) and dat_i[0] |=> imask[0];
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("ier"); // RQ16
	property p_irq_clear;
		@(posedge clk_i) disable iff (rst_i)
		s_write(ADDR_IRQ_CLEAR) and dat_i[1] |=> !imask[1];
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("idr"); // RQ17
	property p_irq_out;
		@(posedge clk_i) disable iff (rst_i)
		##1 irq_o == $past(irq_any);
	endproperty
	a_irq_out: assert property (p_irq_out) else $error("irq"); // RQ21
endmodule : sync_serial_status_and_holding

//--- sync_serial_pkg.sv
// Constants shared by the sync serial status and holding block
package sync_serial_pkg;
	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [31:0] ADDR_RX_HOLDING = 32'hFFFBC020;
	localparam logic [31:0] ADDR_TX_HOLDING = 32'hFFFBC024;
	localparam logic [31:0] ADDR_RX_SYNC = 32'hFFFBC030;
	localparam logic [31:0] ADDR_TX_SYNC = 32'hFFFBC034;
	localparam logic [31:0] ADDR_MATCH_A = 32'hFFFBC038;
	localparam logic [31:0] ADDR_MATCH_B = 32'hFFFBC03C;
	localparam logic [31:0] ADDR_EVENT_FLAGS = 32'hFFFBC040;
	localparam logic [31:0] ADDR_IRQ_SET = 32'hFFFBC044;
	localparam logic [31:0] ADDR_IRQ_CLEAR = 32'hFFFBC048;
	localparam logic [31:0] ADDR_IRQ_MASK = 32'hFFFBC04C;
	localparam logic [31:0] ADDR_LINK_CTRL = 32'hFFFBC050;
	localparam logic [31:0] ADDR_TX_DMA_COUNT = 32'hFFFBC054;
	localparam logic [31:0] ADDR_TX_DMA_NEXT = 32'hFFFBC058;
	localparam logic [31:0] ADDR_RX_DMA_COUNT = 32'hFFFBC05C;
	localparam logic [31:0] ADDR_RX_DMA_NEXT = 32'hFFFBC060;
	// ----------------------------------------------------------------
	// Status bit positions
	// ----------------------------------------------------------------
	localparam int FLAG_TX_FREE = 0;
	localparam int FLAG_TX_DONE = 1;
	localparam int FLAG_TX_DMA_END = 2;
	localparam int FLAG_TX_DMA_EMPTY = 3;
	localparam int FLAG_RX_READY = 4;
	localparam int FLAG_RX_OVERRUN = 5;
	localparam int FLAG_RX_DMA_END = 6;
	localparam int FLAG_RX_DMA_FULL = 7;
	localparam int FLAG_MATCH_A = 8;
	localparam int FLAG_MATCH_B = 9;
	localparam int FLAG_TX_SYNC = 10;
	localparam int FLAG_RX_SYNC = 11;
	localparam int FLAG_TX_ON = 16;
	localparam int FLAG_RX_ON = 17;
	localparam int IRQ_W = 12;
	// ----------------------------------------------------------------
	// Link control fields
	// ----------------------------------------------------------------
	localparam int CTRL_TX_ON = 0;
	localparam int CTRL_RX_ON = 1;
	localparam int CTRL_LEN_LSB = 4;
	localparam int LEN_W = 5;
	localparam int CTRL_SYNC_SEND = 12;
	localparam int CTRL_SLEN_LSB = 16;
	localparam int SLEN_W = 4;
	localparam logic [31:0] CTRL_RW_MASK = 32'h000F11F3;
	// ----------------------------------------------------------------
	// Widths and indices
	// ----------------------------------------------------------------
	localparam int SYNC_W = 16;
	localparam int CNT_W = 16;
	localparam int BIT_W = 5;
	localparam int CH_TX = 0;
	localparam int CH_RX = 1;
	localparam int N_EVT = 5;
	typedef enum logic [1:0] {TX_IDLE, TX_SYNC, TX_DATA, TX_TAIL} tx_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_SYNC, RX_DATA} rx_state_t;
endpackage : sync_serial_pkg

//--- sync_serial_tx_shifter.sv
// Transmit shifter: sync data phase followed by the data word
`timescale 1ns/1ps
module sync_serial_tx_shifter (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic load_i,
	input wire logic [31:0] word_i,
	input wire logic [sync_serial_pkg::LEN_W-1:0] len_i,
	input wire logic [sync_serial_pkg::SYNC_W-1:0] sync_word_i,
	input wire logic [sync_serial_pkg::SLEN_W-1:0] sync_len_i,
	input wire logic sync_en_i,
	output logic busy_o,
	output logic td_o,
	output logic tf_o,
	output logic sync_start_o
);
	import sync_serial_pkg::*;
	tx_state_t state;
	logic [31:0] word;
	logic [SYNC_W-1:0] sync_word;
	logic [LEN_W-1:0] len;
	logic [SLEN_W-1:0] sync_len;
	logic sync_en;
	logic [BIT_W-1:0] bit_idx;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= TX_IDLE;
			word <= '0;
			sync_word <= '0;
			len <= '0;
			sync_len <= '0;
			sync_en <= 1'b0;
			bit_idx <= '0;
			td_o <= 1'b0;
			tf_o <= 1'b0;
			busy_o <= 1'b0;
			sync_start_o <= 1'b0;
		end else begin
			sync_start_o <= 1'b0;
			case (state)
				TX_IDLE: begin
					if (load_i) begin
						word <= word_i;
						sync_word <= sync_word_i;
						len <= len_i;
						sync_len <= sync_len_i;
						sync_en <= sync_en_i;
						bit_idx <= '0;
						busy_o <= 1'b1;
						sync_start_o <= 1'b1;
						state <= TX_SYNC;
					end
				end
				TX_SYNC: begin
					if (tick_i) begin
						tf_o <= 1'b1;
						// Sync data replaces the idle level
						td_o <= sync_en & sync_word[bit_idx[SLEN_W-1:0]]; // RQ20
						if (bit_idx == {1'b0, sync_len}) begin
							bit_idx <= '0;
							state <= TX_DATA;
						end else begin
							bit_idx <= bit_idx + 1'b1;
						end
					end
				end
				TX_DATA: begin
					if (tick_i) begin
						tf_o <= 1'b0;
						// Length plus one bits, low end first
						td_o <= word[bit_idx]; // RQ19
						if (bit_idx == len) begin
							state <= TX_TAIL;
						end else begin
							bit_idx <= bit_idx + 1'b1;
						end
					end
				end
				TX_TAIL: begin
					if (tick_i) begin
						td_o <= 1'b0;
						busy_o <= 1'b0;
						state <= TX_IDLE;
					end
				end
				default: state <= TX_IDLE;
			endcase
		end
	end
endmodule : sync_serial_tx_shifter

//--- sync_serial_codec_model.sv
// Serial codec model: link clock, receive frames, transmit capture
`timescale 1ns/1ps
module sync_serial_codec_model (
	output logic serial_clk_o,
	output logic rx_data_o,
	output logic rx_sync_o,
	input wire logic tx_data_i,
	input wire logic tx_sync_i
);
	logic [15:0] sync_cap;
	logic [31:0] data_cap;
	int sn;
	int dn;
	initial begin
		serial_clk_o <= 1'b0;
		rx_data_o <= 1'b0;
		rx_sync_o <= 1'b0;
	end
	// Clock runs only inside a frame; spare bits toggle so no stale level
	task frame(input logic [15:0] sw, input logic [31:0] dw, input int ns,
		input int nd, input bit with_sync);
		int i;
		sync_cap = '0;
		data_cap = '0;
		sn = 0;
		dn = 0;
		// Slot 0 carries only the sync rise that starts the frame
		for (i = 0; i < ns + nd + 7; i++) begin
			if (i == 0)
				rx_data_o <= 1'b0;
			else if (i <= ns)
				rx_data_o <= sw[i - 1];
			else if (i <= ns + nd)
				rx_data_o <= dw[i - 1 - ns];
			else
				rx_data_o <= ~rx_data_o;
			rx_sync_o <= with_sync && (i <= ns);
			#40 serial_clk_o <= 1'b1;
			if (tx_sync_i === 1'b1 && sn < 16) begin
				sync_cap[sn] = tx_data_i;
				sn++;
			end else if (sn > 0 && dn < 32) begin
				data_cap[dn] = tx_data_i;
				dn++;
			end
			#40 serial_clk_o <= 1'b0;
		end
		rx_sync_o <= 1'b0;
	endtask : frame
endmodule : sync_serial_codec_model

//--- sync_serial_status_and_holding_tb.sv
// Testbench for the sync serial status and holding block
`timescale 1ns/1ps
module sync_serial_status_and_holding_tb;
	import sync_serial_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [31:0] adr_i = 32'h0;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic ack_o;
	logic serial_clk;
	logic rx_data;
	logic rx_sync;
	logic tx_data;
	logic tx_sync;
	logic irq_o;
	logic [31:0] rdata;
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;
	always #2.5 clk_i = ~clk_i;
	sync_serial_status_and_holding dut (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.serial_clk_i(serial_clk), .rx_data_i(rx_data),
		.rx_sync_i(rx_sync), .tx_data_o(tx_data), .tx_sync_o(tx_sync),
		.irq_o(irq_o));
	sync_serial_codec_model codec (.serial_clk_o(serial_clk),
		.rx_data_o(rx_data), .rx_sync_o(rx_sync), .tx_data_i(tx_data),
		.tx_sync_i(tx_sync));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			end_of_test();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task acc(input bit w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hF;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		rdata = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		if (n >= 50) begin
			miscompares++;
			end_of_test();
		end
	endtask : acc
	task rchk(input logic [31:0] a, input logic [31:0] m,
		input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(rdata & m, e);
	endtask : rchk
	task irq_chk(input logic e);
		repeat (4) @(posedge clk_i);
		chk({31'h0, irq_o}, {31'h0, e});
	endtask : irq_chk
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_reset;
		rchk(ADDR_EVENT_FLAGS, 32'hFFFFFFFF, 32'h0000008B);
		rchk(ADDR_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
		rchk(ADDR_RX_SYNC, 32'hFFFFFFFF, 32'h0);
		rchk(ADDR_TX_HOLDING, 32'hFFFFFFFF, 32'h0);
		rchk(32'hFFFBC0FC, 32'hFFFFFFFF, 32'h0);
		irq_chk(1'b0);
	endtask : t_reset
	task t_regs;
		logic [31:0] a [3];
		int i;
		a = '{ADDR_TX_SYNC, ADDR_MATCH_A, ADDR_MATCH_B};
		for (i = 0; i < 3; i++) begin
			acc(1'b1, a[i], 32'hFFFF1234 + i);
			rchk(a[i], 32'hFFFFFFFF, 32'h00001234 + i);
		end
	endtask : t_regs
	task t_mask;
		acc(1'b1, ADDR_IRQ_SET, 32'h00000F0F);
		acc(1'b1, ADDR_IRQ_SET, 32'h0);
		acc(1'b1, ADDR_IRQ_CLEAR, 32'h00000003);
		rchk(ADDR_IRQ_MASK, 32'hFFFFFFFF, 32'h00000F0C);
		irq_chk(1'b1);
		acc(1'b1, ADDR_IRQ_CLEAR, 32'hFFFFFFFF);
		rchk(ADDR_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
		irq_chk(1'b0);
	endtask : t_mask
	task t_tx;
		acc(1'b1, ADDR_TX_DMA_COUNT, 32'h1);
		rchk(ADDR_EVENT_FLAGS, 32'hF, 32'h3);
		acc(1'b1, ADDR_TX_SYNC, 32'h000A);
		acc(1'b1, ADDR_LINK_CTRL, 32'h00031070);
		acc(1'b1, ADDR_TX_HOLDING, 32'h000001A5);
		rchk(ADDR_EVENT_FLAGS, 32'h3, 32'h0);
		acc(1'b1, ADDR_LINK_CTRL, 32'h00031071);
		codec.frame(16'h0, 32'h0, 4, 8, 1'b0);
		chk({16'h0, codec.sync_cap}, 32'h0000000A);
		chk(codec.data_cap, 32'h000000A5);
		rchk(ADDR_EVENT_FLAGS, 32'h0003040F, 32'h0001040F);
		rchk(ADDR_EVENT_FLAGS, 32'h0003040F, 32'h0001000F);
		acc(1'b1, ADDR_TX_DMA_NEXT, 32'h0);
		rchk(ADDR_EVENT_FLAGS, 32'hC, 32'h8);
		acc(1'b1, ADDR_LINK_CTRL, 32'h00030071);
		acc(1'b1, ADDR_TX_HOLDING, 32'h0000015A);
		codec.frame(16'h0, 32'h0, 4, 8, 1'b0);
		chk({16'h0, codec.sync_cap}, 32'h0);
		chk(codec.data_cap, 32'h0000005A);
		rchk(ADDR_EVENT_FLAGS, 32'h0003040F, 32'h0001040B);
	endtask : t_tx
	task t_rx;
		acc(1'b1, ADDR_MATCH_A, 32'h5A);
		acc(1'b1, ADDR_MATCH_B, 32'h33);
		acc(1'b1, ADDR_RX_DMA_COUNT, 32'h1);
		acc(1'b1, ADDR_LINK_CTRL, 32'h00031072);
		acc(1'b1, ADDR_IRQ_SET, 32'h10);
		rchk(ADDR_EVENT_FLAGS, 32'hC0, 32'h0);
		codec.frame(16'hC, 32'h5A, 4, 8, 1'b1);
		irq_chk(1'b1);
		codec.frame(16'h3, 32'h33, 4, 8, 1'b1);
		rchk(ADDR_RX_SYNC, 32'hFFFFFFFF, 32'h3);
		rchk(ADDR_EVENT_FLAGS, 32'h00030FF0, 32'h00020BF0);
		rchk(ADDR_EVENT_FLAGS, 32'h00030FF0, 32'h000200D0);
		rchk(ADDR_RX_HOLDING, 32'hFFFFFFFF, 32'h33);
		rchk(ADDR_EVENT_FLAGS, 32'h10, 32'h0);
		irq_chk(1'b0);
		acc(1'b1, ADDR_RX_DMA_NEXT, 32'h0);
		rchk(ADDR_EVENT_FLAGS, 32'hC0, 32'h80);
	endtask : t_rx
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_regs();
		t_mask();
		t_tx();
		t_rx();
		end_of_test();
	end
endmodule : sync_serial_status_and_holding_tb
